//--- ppa_accumulator.sv
// Pulse width / period accumulator channel with a plain register port
//
// Strobed register access and the placing of the registers were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
module ppa_accumulator #(
   parameter int WIDTH = 24 // Timebase and accumulator width
) (
   input wire logic mclk, // 100 MHz clock
   input wire logic nrst, // Synchronous reset, active low
   input wire logic sigIn, // Measured signal, asynchronous
   input wire logic tbTickOne, // Timebase one count enable
   input wire logic tbTickTwo, // Timebase two count enable
   input wire ppa_pkg::ppa_req_s busReq, // Register request
   output logic [31:0] rdData, // Read data, cycle after read strobe
   output logic irqFlag, // Interrupt status flag
   output logic dmaReq // DMA request flag
);
   // Overview
   // The channel waits for a service request while enabled, then for the
   // edge that opens a measurement. Each closing edge adds one width or
   // period to the running total and one to the count. When the count
   // reaches the target, a three-step sequence copies the total, then the
   // status, and finally raises the interrupt and DMA flags; the next run
   // then starts from zero without help from software.
   // Limitation: edges that arrive during those three steps are not measured.
   // Trade-off: one shared adder serves both closing edges and interim refresh.
   // Elaboration guard: field packing and read-back widths assume 24-bit words
   // A narrower word would truncate host writes; a wider one breaks the read path
   if (WIDTH != 24) begin : g_badWidth
      $error("WIDTH must be 24");
   end

   // Synchroniser state
   // Only stages two and three are compared; stage one may still be settling
   logic [2:0] sync_r; // Three-stage input chain
   logic level_r; // Accepted input level
   logic [1:0] tbSync_r; // Timebase enables, same domain
   // Parameter and control registers
   // The device owns total, flag word and count once a run is open
   // Software only presets them while the channel is halted
   logic [WIDTH-1:0] total_r; // running_total
   logic [7:0] accFlag_r; // accum_overflow_flag
   logic [WIDTH-1:0] interval_r; // interim_update_interval
   logic [WIDTH-1:0] count_r; // accumulated_count
   logic [WIDTH-1:0] target_r; // target_count
   logic [WIDTH-1:0] result_r; // final_total
   logic [7:0] status_r; // final_overflow_status
   logic enable_r; // Channel enabled
   ppa_pkg::ppa_mode_e mode_r; // Selected mode
   ppa_pkg::ppa_mode_e modeRun_r; // Mode latched at service request
   logic tbSel_r; // Timebase choice
   logic hsr_r; // Pending host_service_request
   // Measurement machine
   // Widths are differences of a free-running count, not a per-pulse counter
   // Base plus width rebuilds the total, so an interim refresh loses nothing
   typedef enum {ST_IDLE, ST_WAIT, ST_ACTIVE} ppa_state_e;
   ppa_state_e state_r; // Current phase
   logic [WIDTH-1:0] tbNow_r; // Free-running selected timebase
   logic [WIDTH-1:0] lastEdge_r; // last_edge_time, private
   logic [WIDTH-1:0] sampleCnt_r; // Ticks since last interim update
   logic [WIDTH-1:0] base_r; // Total at start of current pulse
   logic baseOvf_r; // Overflow flag at start of pulse
   logic [1:0] finish_r; // Completion sequence stage

   // Shared decode of register offsets
   // Used by every write path and by the flag clear
   function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
      hit = (a == ofs);
   endfunction

   // Input synchroniser; stage 0 only feeds stage 1
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         sync_r <= 3'h0;
         level_r <= 1'b0;
      end else begin
         // A glitch shorter than two cycles never reaches the accepted level
         sync_r <= {sync_r[1:0], sigIn};
         if (sync_r[2] == sync_r[1]) begin // Change counts once stages agree
            level_r <= sync_r[2];
         end
      end
   end

   // Edge decode relative to the accepted level
   // An edge shows one cycle before level_r follows, so each change fires once
   logic risingEdge; // Accepted rise
   logic fallingEdge; // Accepted fall
   logic startEdge; // Edge that opens a measurement
   logic endEdge; // Edge that closes one
   logic tick; // Selected timebase count
   always_comb begin
      risingEdge = (sync_r[2] == sync_r[1]) && sync_r[2] && !level_r;
      fallingEdge = (sync_r[2] == sync_r[1]) && !sync_r[2] && level_r;
      tick = tbSel_r ? tbSync_r[1] : tbSync_r[0];
      case (modeRun_r)
         // Low width: opens on fall, closes on rise
         ppa_pkg::MODE_LOW: begin
            startEdge = fallingEdge;
            endEdge = risingEdge;
         end
         // High width: opens on rise, closes on fall
         ppa_pkg::MODE_HIGH: begin
            startEdge = risingEdge;
            endEdge = fallingEdge;
         end
         // Start and end are the same edge in the period modes
         ppa_pkg::MODE_FALL: begin
            startEdge = fallingEdge;
            endEdge = fallingEdge;
         end
         // Rising period
         default: begin
            startEdge = risingEdge;
            endEdge = risingEdge;
         end
      endcase
   end

   // Timebase capture; the width counter is the selected free-running timebase
   // It runs whether or not a run is open, so a width is two snapshots apart
   // Timebase two may tick slower; only the chosen one advances the count
   // No reset of the count between runs: only differences are ever used
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         tbSync_r <= 2'h0;
         tbNow_r <= ppa_pkg::RST_WORD;
      end else begin
         tbSync_r <= {tbTickTwo, tbTickOne};
         if (tick) begin
            tbNow_r <= tbNow_r + 1'b1;
         end
      end
   end

   // Width of the pulse in progress, modulo 24 bits
   // Wrap of the timebase is harmless while one pulse is shorter than its range
   // The guard bit of the sum is the carry out that marks overflow
   // A target of zero is served as one, so every edge pair completes
   logic [WIDTH-1:0] elapsed; // Current width
   logic [WIDTH:0] sum; // Base plus width, one guard bit
   logic [WIDTH-1:0] effTarget; // Target with 0 treated as 1
   always_comb begin
      elapsed = tbNow_r - lastEdge_r;
      sum = {1'b0, base_r} + {1'b0, elapsed};
      effTarget = (target_r == ppa_pkg::RST_WORD) ? 24'h000001 : target_r;
   end

   // Control register and mode-change detection
   logic modeWrite; // Host writes control
   assign modeWrite = busReq.wr && hit(busReq.addr, ppa_pkg::OFS_CTRL);
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         enable_r <= ppa_pkg::RST_CTRL[ppa_pkg::CTRL_EN];
         mode_r <= ppa_pkg::ppa_mode_e'(ppa_pkg::RST_CTRL[ppa_pkg::CTRL_MODE_LO +: 2]);
         tbSel_r <= ppa_pkg::RST_CTRL[ppa_pkg::CTRL_TB];
         hsr_r <= ppa_pkg::RST_CTRL[ppa_pkg::CTRL_HSR];
      end else if (modeWrite) begin
         enable_r <= busReq.wdata[ppa_pkg::CTRL_EN];
         mode_r <= ppa_pkg::ppa_mode_e'(busReq.wdata[ppa_pkg::CTRL_MODE_LO +: 2]);
         tbSel_r <= busReq.wdata[ppa_pkg::CTRL_TB];
         // Request is set-only: the enabling write that follows it carries a zero
         // there and must not cancel it before it is served
         if (busReq.wdata[ppa_pkg::CTRL_HSR]) begin
            hsr_r <= 1'b1;
         end
      end else if (hsr_r && enable_r) begin
         hsr_r <= 1'b0; // Request served once enabled
      end
   end

   // Measurement sequencer: edges, interim updates, completion
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         // Everything the device owns starts from zero
         state_r <= ST_IDLE;
         modeRun_r <= ppa_pkg::MODE_LOW;
         total_r <= ppa_pkg::RST_WORD;
         accFlag_r <= ppa_pkg::STAT_NONE;
         count_r <= ppa_pkg::RST_WORD;
         result_r <= ppa_pkg::RST_WORD;
         status_r <= ppa_pkg::STAT_NONE;
         lastEdge_r <= ppa_pkg::RST_WORD;
         sampleCnt_r <= ppa_pkg::RST_WORD;
         base_r <= ppa_pkg::RST_WORD;
         baseOvf_r <= 1'b0;
         finish_r <= 2'h0;
      end else begin
         // Host writes to device-owned words
         // Device updates further down win over a host write in the same cycle
         if (busReq.wr && hit(busReq.addr, ppa_pkg::OFS_TOTAL)) begin
            total_r <= busReq.wdata[WIDTH-1:0];
            base_r <= busReq.wdata[WIDTH-1:0];
         end
         if (busReq.wr && hit(busReq.addr, ppa_pkg::OFS_ACCFLAG)) begin
            accFlag_r <= busReq.wdata[7:0];
            baseOvf_r <= busReq.wdata[7];
         end
         if (busReq.wr && hit(busReq.addr, ppa_pkg::OFS_COUNT)) begin
            count_r <= busReq.wdata[WIDTH-1:0];
         end
         // Completion sequence, one step a cycle
         case (finish_r)
            // Step one: result first, so status never describes a stale total
            2'h1: begin
               result_r <= total_r;
               finish_r <= 2'h2;
            end
            // Step two: status, then clear the working words for the next run
            2'h2: begin
               status_r <= accFlag_r;
               accFlag_r <= ppa_pkg::STAT_NONE;
               baseOvf_r <= 1'b0;
               total_r <= ppa_pkg::RST_WORD;
               base_r <= ppa_pkg::RST_WORD;
               count_r <= ppa_pkg::RST_WORD;
               finish_r <= 2'h3;
            end
            2'h3: finish_r <= 2'h0; // Flags raised in this step
            default: finish_r <= 2'h0;
         endcase
         // Halt wins; a pending service request waits for enable
         if (!enable_r) begin
            state_r <= ST_IDLE; // Halted channel
         end else if (hsr_r) begin
            // Latch the mode; later control writes are compared against it
            modeRun_r <= mode_r;
            state_r <= ST_WAIT;
         end else if (state_r != ST_IDLE && mode_r != modeRun_r) begin
            // Mode altered while running: invalid state reported
            // Only a fresh service request restarts the channel
            status_r <= status_r | ppa_pkg::STAT_BADMODE;
            state_r <= ST_IDLE;
         end else if (finish_r == 2'h0) begin
            case (state_r)
               // Waiting for the edge that opens a pulse or period
               ST_WAIT: begin
                  if (startEdge) begin
                     lastEdge_r <= tbNow_r;
                     sampleCnt_r <= ppa_pkg::RST_WORD;
                     state_r <= ST_ACTIVE;
                  end
               end
               // Closing edge: fold width into total, bump count, test target
               ST_ACTIVE: begin
                  if (endEdge) begin
                     total_r <= sum[WIDTH-1:0];
                     base_r <= sum[WIDTH-1:0];
                     // Overflow sticks through baseOvf_r until the result is delivered
                     if (sum[WIDTH] || baseOvf_r) begin
                        accFlag_r <= ppa_pkg::STAT_OVF;
                        baseOvf_r <= 1'b1;
                     end
                     count_r <= count_r + 1'b1;
                     // Incremented count, so a target of n closes on the nth edge
                     if (count_r + 1'b1 >= effTarget) begin
                        finish_r <= 2'h1;
                     end
                     // Period modes reopen at once on the same edge
                     // so no timebase tick is lost between two periods
                     state_r <= (modeRun_r == ppa_pkg::MODE_FALL ||
                                 modeRun_r == ppa_pkg::MODE_RISE) ? ST_ACTIVE : ST_WAIT;
                     lastEdge_r <= tbNow_r;
                     sampleCnt_r <= ppa_pkg::RST_WORD;
                  end else if (tick) begin
                     // Interim refresh only when the interval elapses first
                     // An interval of zero switches interim refresh off
                     if (sampleCnt_r + 1'b1 >= interval_r &&
                         interval_r != ppa_pkg::RST_WORD) begin
                        total_r <= sum[WIDTH-1:0];
                        if (sum[WIDTH] || baseOvf_r) begin
                           accFlag_r <= ppa_pkg::STAT_OVF;
                        end
                        sampleCnt_r <= ppa_pkg::RST_WORD;
                     end else begin
                        sampleCnt_r <= sampleCnt_r + 1'b1;
                     end
                  end
               end
               default: state_r <= ST_IDLE;
            endcase
         end
      end
   end

   // Host-writable interval and target
   // A new interval applies at once, against the ticks already counted
   // Both words are host-owned and never touched by the device
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         interval_r <= ppa_pkg::RST_WORD;
         target_r <= ppa_pkg::RST_WORD;
      end else if (busReq.wr) begin
         if (hit(busReq.addr, ppa_pkg::OFS_INTERVAL)) begin
            interval_r <= busReq.wdata[WIDTH-1:0];
         end
         if (hit(busReq.addr, ppa_pkg::OFS_TARGET)) begin
            target_r <= busReq.wdata[WIDTH-1:0];
         end
      end
   end

   // Interrupt and DMA flags; set wins over a same-cycle clear
   // A clear that lands on the completion step is dropped on purpose,
   // so software cannot lose a fresh result; flags stay until cleared
   // Both flags rise together on the last step of the completion
   logic flagClr; // Host clear write
   assign flagClr = busReq.wr && hit(busReq.addr, ppa_pkg::OFS_FLAGS);
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         irqFlag <= 1'b0;
         dmaReq <= 1'b0;
      end else if (finish_r == 2'h3) begin
         irqFlag <= 1'b1;
         dmaReq <= 1'b1;
      end else if (flagClr) begin
         if (busReq.wdata[ppa_pkg::FLG_IRQ]) irqFlag <= 1'b0;
         if (busReq.wdata[ppa_pkg::FLG_DMA]) dmaReq <= 1'b0;
      end
   end

   // Read data, valid the cycle after the strobe; unmapped reads zero
   // Zero outside the data cycle keeps a late sample from looking valid
   // Words are right-aligned; control shows a request until it is served
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         rdData <= 32'h00000000;
      end else if (busReq.rd) begin
         case (busReq.addr)
            ppa_pkg::OFS_TOTAL: rdData <= {8'h00, total_r};
            ppa_pkg::OFS_ACCFLAG: rdData <= {24'h000000, accFlag_r};
            ppa_pkg::OFS_INTERVAL: rdData <= {8'h00, interval_r};
            ppa_pkg::OFS_COUNT: rdData <= {8'h00, count_r};
            ppa_pkg::OFS_TARGET: rdData <= {8'h00, target_r};
            ppa_pkg::OFS_RESULT: rdData <= {8'h00, result_r};
            ppa_pkg::OFS_STATUS: rdData <= {24'h000000, status_r};
            ppa_pkg::OFS_CTRL: rdData <= {27'h0000000, hsr_r, tbSel_r, mode_r, enable_r};
            ppa_pkg::OFS_FLAGS: rdData <= {30'h00000000, dmaReq, irqFlag};
            default: rdData <= 32'h00000000;
         endcase
      end else begin
         rdData <= 32'h00000000;
      end
   end
endmodule
`default_nettype wire

//--- ppa_pkg.sv
// Package: register map, field layout, reset values and types for the pulse/period accumulator
package ppa_pkg;
   // Register offsets (byte addresses on the plain port)
   localparam logic [7:0] OFS_TOTAL = 8'h00; // running_total
   localparam logic [7:0] OFS_ACCFLAG = 8'h04; // accum_overflow_flag
   localparam logic [7:0] OFS_INTERVAL = 8'h08; // interim_update_interval
   localparam logic [7:0] OFS_COUNT = 8'h0c; // accumulated_count
   localparam logic [7:0] OFS_TARGET = 8'h10; // target_count
   localparam logic [7:0] OFS_RESULT = 8'h14; // final_total
   localparam logic [7:0] OFS_STATUS = 8'h18; // final_overflow_status
   localparam logic [7:0] OFS_CTRL = 8'h1c; // control: enable, mode, timebase, service request
   localparam logic [7:0] OFS_FLAGS = 8'h20; // interrupt status and DMA request, write 1 to clear
   // Control field positions
   localparam int CTRL_EN = 0; // Channel enabled (nonzero priority)
   localparam int CTRL_MODE_LO = 1; // Mode field, two bits
   localparam int CTRL_TB = 3; // Timebase select
   localparam int CTRL_HSR = 4; // Host service request, self-clearing
   // Flag positions
   localparam int FLG_IRQ = 0; // Interrupt status flag
   localparam int FLG_DMA = 1; // DMA request flag
   // Status bit values
   localparam logic [7:0] STAT_OVF = 8'h80; // Overflow indication
   localparam logic [7:0] STAT_BADMODE = 8'h03; // Mode altered mid-measurement
   localparam logic [7:0] STAT_NONE = 8'h00; // Clean measurement
   // Reset values
   localparam logic [23:0] RST_WORD = 24'h000000; // All parameter words
   localparam logic [4:0] RST_CTRL = 5'h00; // Disabled, low-pulse mode, timebase one
   // Measurement modes
   typedef enum logic [1:0] {MODE_LOW, MODE_HIGH, MODE_FALL, MODE_RISE} ppa_mode_e;
   // Register port request bundle
   typedef struct packed {
      logic [7:0] addr; // Byte address
      logic [31:0] wdata; // Write data
      logic wr; // Write strobe
      logic rd; // Read strobe
   } ppa_req_s;
endpackage

//--- ppa_accumulator_sva.sv
// Port checker for the pulse/period accumulator
`timescale 1ns/1ns
`default_nettype none
module ppa_accumulator_chk (
   input wire logic mclk, // Clock
   input wire logic nrst, // Sync reset, active low
   input wire logic sigIn, // Measured signal
   input wire logic tbTickOne, // Timebase one enable
   input wire logic tbTickTwo, // Timebase two enable
   input wire ppa_pkg::ppa_req_s busReq, // Register request
   input wire logic [31:0] rdData, // Read data
   input wire logic irqFlag, // Interrupt status flag
   input wire logic dmaReq // DMA request flag
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!nrst);
   logic prevSig_r; // Last input level seen
   logic [3:0] sinceEdge_r; // Cycles since input toggled
   // Edge age; saturates so a long idle never wraps back to small
   always_ff @(posedge mclk) begin
      prevSig_r <= sigIn;
      if (!nrst) begin // Treat reset as long idle
         sinceEdge_r <= 4'hf;
      end else if (sigIn != prevSig_r) begin // Fresh edge
         sinceEdge_r <= 4'h0;
      end else if (sinceEdge_r != 4'hf) begin // Ageing
         sinceEdge_r <= sinceEdge_r + 4'h1;
      end
   end
   // Read strobe at one address
   sequence s_rdAt(logic [7:0] a);
      busReq.rd && busReq.addr == a;
   endsequence
   // Write one-to-clear on a flag bit; a function, since it is negated below
   function automatic logic clrBit(input ppa_pkg::ppa_req_s r, input int b);
      clrBit = r.wr && r.addr == ppa_pkg::OFS_FLAGS && r.wdata[b];
   endfunction
   a_status_bits_only: assert property (s_rdAt(ppa_pkg::OFS_STATUS) |=>
      rdData[31:8] == 24'h0 && rdData[6:2] == 5'h0) else $error("status has stray bits");
   a_accflag_value: assert property (s_rdAt(ppa_pkg::OFS_ACCFLAG) |=>
      rdData == 32'h0 || rdData == 32'h80) else $error("overflow flag word illegal");
   a_total_width: assert property (s_rdAt(ppa_pkg::OFS_TOTAL) |=>
      rdData[31:24] == 8'h0) else $error("running total wider than 24 bits");
   a_result_width: assert property (s_rdAt(ppa_pkg::OFS_RESULT) |=>
      rdData[31:24] == 8'h0) else $error("result wider than 24 bits");
   a_count_width: assert property (s_rdAt(ppa_pkg::OFS_COUNT) |=>
      rdData[31:24] == 8'h0) else $error("count wider than 24 bits");
   a_irq_dma_pair: assert property ($rose(irqFlag) |-> dmaReq)
      else $error("interrupt and DMA flags not raised together");
   a_irq_sticky: assert property (irqFlag && !clrBit(busReq, ppa_pkg::FLG_IRQ) |=> irqFlag)
      else $error("interrupt flag dropped without clear");
   a_dma_sticky: assert property (dmaReq && !clrBit(busReq, ppa_pkg::FLG_DMA) |=> dmaReq)
      else $error("DMA flag dropped without clear");
   a_irq_after_edge: assert property ($rose(irqFlag) |-> sinceEdge_r <= 4'hc)
      else $error("completion without a recent edge");
endmodule
bind ppa_accumulator ppa_accumulator_chk u_ppa_accumulator_chk (.mclk(mclk), .nrst(nrst),
   .sigIn(sigIn), .tbTickOne(tbTickOne), .tbTickTwo(tbTickTwo), .busReq(busReq),
   .rdData(rdData), .irqFlag(irqFlag), .dmaReq(dmaReq));
`default_nettype wire

//--- ppa_sig_src.sv
// Model of the external signal being measured
`timescale 1ns/1ns
`default_nettype none
module ppa_sig_src (
   input wire logic mclk, // Bench clock
   output var logic sigOut // Measured signal
);
   // Idle low, so the first change is a rising edge
   initial sigOut = 1'b0;
   // Hold a level n cycles; call just after a rising edge
   task automatic level(input logic v, input int n);
      sigOut <= v;
      repeat (n) @(posedge mclk);
   endtask
   // High for hi cycles, then low for lo cycles
   task automatic pulse(input int hi, input int lo);
      level(1'b1, hi);
      level(1'b0, lo);
   endtask
endmodule
`default_nettype wire

//--- tb_ppa_accumulator.sv
// Self-checking bench for the pulse/period accumulator
`timescale 1ns/1ns
`default_nettype none
module tb_ppa_accumulator;
   logic mclk; // 100 MHz clock
   logic nrst; // Reset, active low
   logic sigIn; // Signal from the model
   logic tickOne; // Timebase one, every cycle
   logic tickTwo; // Timebase two, every other cycle
   ppa_pkg::ppa_req_s busReq; // Register request
   logic [31:0] rdData; // Read data
   logic irqFlag; // Interrupt status
   logic dmaReq; // DMA request
   int fail_count; // Mismatches
   int n_checks; // Comparisons
   logic [31:0] d; // Scratch read value
   ppa_accumulator u_ppa_accumulator (.mclk(mclk), .nrst(nrst), .sigIn(sigIn),
      .tbTickOne(tickOne), .tbTickTwo(tickTwo), .busReq(busReq), .rdData(rdData),
      .irqFlag(irqFlag), .dmaReq(dmaReq));
   ppa_sig_src u_ppa_sig_src (.mclk(mclk), .sigOut(sigIn));
   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   // Half-rate timebase so the two selections give different totals
   always @(posedge mclk) tickTwo <= ~tickTwo;
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge mclk);
      busReq <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
      @(posedge mclk);
      busReq.wr <= 1'b0;
   endtask
   // Data stands only in the cycle after the strobe
   task automatic rd(input logic [7:0] a, output logic [31:0] v);
      @(posedge mclk);
      busReq <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
      @(posedge mclk);
      busReq.rd <= 1'b0;
      #1 v = rdData;
   endtask
   task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
      rd(a, d);
      chk(d, exp);
   endtask
   // Halt, load words, request service, then enable
   task automatic setup(input logic [4:0] ctl, input logic [23:0] tgt, input logic [23:0] ivl,
         input logic [23:0] tot);
      wr(ppa_pkg::OFS_CTRL, 32'h0);
      wr(ppa_pkg::OFS_TOTAL, {8'h0, tot});
      wr(ppa_pkg::OFS_ACCFLAG, 32'h0);
      wr(ppa_pkg::OFS_COUNT, 32'h0);
      wr(ppa_pkg::OFS_TARGET, {8'h0, tgt});
      wr(ppa_pkg::OFS_INTERVAL, {8'h0, ivl});
      wr(ppa_pkg::OFS_FLAGS, 32'h3);
      wr(ppa_pkg::OFS_CTRL, {27'h0, ctl | 5'h10});
      wr(ppa_pkg::OFS_CTRL, {27'h0, ctl | 5'h01});
      @(posedge mclk);
   endtask
   task automatic t_reset();
      for (int a = 0; a <= 36; a += 4) rdchk(a[7:0], 32'h0);
   endtask
   // Three pulses per mode, two units per result
   task automatic t_modes();
      logic [23:0] exp [4] = '{24'd40, 24'd24, 24'd64, 24'd64};
      for (int m = 0; m < 4; m++) begin
         setup({2'b00, m[1:0], 1'b0}, 24'd2, 24'd0, 24'd0);
         repeat (3) u_ppa_sig_src.pulse(12, 20);
         chk({30'h0, dmaReq, irqFlag}, 32'h3);
         rdchk(ppa_pkg::OFS_RESULT, {8'h0, exp[m]});
         rdchk(ppa_pkg::OFS_STATUS, 32'h0);
         rdchk(ppa_pkg::OFS_COUNT, (m == 1) ? 32'h1 : 32'h0);
         rdchk(ppa_pkg::OFS_TOTAL, (m == 1) ? 32'd12 : 32'h0);
         rdchk(ppa_pkg::OFS_FLAGS, 32'h3);
         wr(ppa_pkg::OFS_FLAGS, 32'h3);
         rdchk(ppa_pkg::OFS_FLAGS, 32'h0);
      end
   endtask
   // Timebase two, targets zero and one keep only the last pulse
   task automatic t_single();
      for (int t = 0; t < 2; t++) begin
         setup(5'h0a, t[23:0], 24'd0, 24'd0);
         u_ppa_sig_src.pulse(12, 20);
         u_ppa_sig_src.pulse(16, 20);
         rdchk(ppa_pkg::OFS_RESULT, 32'd8);
         rdchk(ppa_pkg::OFS_COUNT, 32'h0);
      end
   endtask
   // Preset total near the top so the first width wraps
   task automatic t_overflow();
      setup(5'h02, 24'd2, 24'd0, 24'hfffff8);
      u_ppa_sig_src.pulse(12, 20);
      rdchk(ppa_pkg::OFS_ACCFLAG, 32'h80);
      u_ppa_sig_src.pulse(12, 20);
      rdchk(ppa_pkg::OFS_RESULT, 32'd16);
      rdchk(ppa_pkg::OFS_STATUS, {24'h0, ppa_pkg::STAT_OVF});
      rdchk(ppa_pkg::OFS_ACCFLAG, 32'h0);
   endtask
   // Mode switched while a measurement is running
   task automatic t_badmode();
      setup(5'h02, 24'd2, 24'd0, 24'd0);
      u_ppa_sig_src.pulse(12, 20);
      wr(ppa_pkg::OFS_CTRL, 32'h1);
      repeat (4) @(posedge mclk);
      rd(ppa_pkg::OFS_STATUS, d);
      chk(d & 32'h3, 32'h3);
   endtask
   // Long high pulse, total read before it ends
   task automatic t_interim(input logic [23:0] ivl, input logic [31:0] lo, input logic [31:0] hi);
      setup(5'h02, 24'd1, ivl, 24'd0);
      u_ppa_sig_src.level(1'b1, 40);
      rd(ppa_pkg::OFS_TOTAL, d);
      chk({31'h0, d >= lo && d <= hi}, 32'h1);
      u_ppa_sig_src.level(1'b0, 20);
   endtask
   task automatic wrap_up();
      if (fail_count == 0 && n_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   initial begin
      nrst = 1'b0;
      tickOne = 1'b1;
      tickTwo = 1'b0;
      busReq = '0;
      fail_count = 0;
      n_checks = 0;
      repeat (3) @(posedge mclk);
      nrst <= 1'b1;
      t_reset();
      t_modes();
      t_single();
      t_overflow();
      t_badmode();
      t_interim(24'd8, 32'd8, 32'd40);
      t_interim(24'd100, 32'd0, 32'd0);
      wrap_up();
   end
   // Hang guard, about ten times the expected run
   initial begin
      #100000;
      fail_count++;
      wrap_up();
   end
endmodule
`default_nettype wire
